//--- rtl/oda_consts.svh
`ifndef ODA_CONSTS_SVH
`define ODA_CONSTS_SVH
// Output and source counts.
`define ODA_NUM_OUT 9
`define ODA_NUM_PLL 4
// Reset values of the divider counters.
`define ODA_CNT_RST 8'h00
// Prescaler ratio required for aligned outputs.
`define ODA_PRE_ALIGN 8'h01
// Linear ratios permitted for aligned outputs.
`define ODA_LIN_A 8'h02
`define ODA_LIN_B 8'h04
`define ODA_LIN_C 8'h06
`define ODA_LIN_D 8'h0C
// PLL frequency window in MHz.
`define ODA_PLL_MIN_MHZ 100
`define ODA_PLL_MAX_MHZ 400
// Cycles of common reset held after power-up before release.
`define ODA_START_CYC 4'h4
`endif

//--- rtl/oda_pkg.sv
`default_nettype none
package oda_pkg;
   // Per-output divider configuration.
   typedef struct packed {
      logic [1:0] pllSel;
      logic [7:0] preRatio;
      logic [7:0] linRatio;
   } oda_div_cfg_t;
   // Startup sequence states.
   typedef enum logic [2:0] {
      ODA_HOLD = 3'b001,
      ODA_RUN = 3'b010,
      ODA_LOST = 3'b100
   } oda_state_t;
endpackage : oda_pkg
`default_nettype wire

//--- rtl/oda_divider.sv
`include "oda_consts.svh"
`default_nettype none
// One output path: prescaler followed by a linear divider.
module oda_divider (
   input wire logic clk,
   input wire logic rst,
   input wire logic syncRst,
   input wire logic [7:0] preRatio,
   input wire logic [7:0] linRatio,
   output logic clkOut
);
   logic [7:0] preCnt_q, preCnt_d, linCnt_q, linCnt_d;
   logic out_q, out_d;
   logic preTick;
   logic [7:0] half;

   // Prescaler ticks once per preRatio cycles; linear stage toggles at half of its ratio.
   always_comb begin
      half = {1'b0, linRatio[7:1]};
      preTick = (preCnt_q + 8'h01 >= preRatio);
      preCnt_d = preTick ? `ODA_CNT_RST : preCnt_q + 8'h01;
      linCnt_d = linCnt_q;
      out_d = out_q;
      if (preTick) begin
         linCnt_d = (linCnt_q + 8'h01 >= linRatio) ? `ODA_CNT_RST : linCnt_q + 8'h01;
         out_d = (linCnt_d < half) ? 1'b1 : 1'b0;
      end
      // Park the linear stage on its last count so every member rises on the first edge.
      if (syncRst) begin
         preCnt_d = `ODA_CNT_RST;
         linCnt_d = linRatio - 8'h01;
         out_d = 1'b0;
      end
   end

   // Counters and output flop.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preCnt_q <= `ODA_CNT_RST;
         linCnt_q <= `ODA_CNT_RST;
         out_q <= 1'b0;
      end else begin
         preCnt_q <= preCnt_d;
         linCnt_q <= linCnt_d;
         out_q <= out_d;
      end
   end
   assign clkOut = out_q;
endmodule : oda_divider
`default_nettype wire

//--- rtl/output_divider_edge_align.sv
`include "oda_consts.svh"
`default_nettype none
module output_divider_edge_align #(
   parameter int NUM_OUT = `ODA_NUM_OUT,
   parameter int NUM_PLL = `ODA_NUM_PLL,
   parameter logic [8:0] ALIGN_MASK = 9'h00F,
   parameter logic [1:0] ALIGN_PLL = 2'h0,
   parameter int PLL_MHZ = 240
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_PLL-1:0] pllClkEn,
   input wire oda_pkg::oda_div_cfg_t [NUM_OUT-1:0] divCfg,
   input wire logic freq_select_bit0,
   input wire logic freq_select_bit1,
   input wire logic freq_select_bit2,
   output logic [NUM_OUT-1:0] clkOut,
   output logic alignValid,
   output logic alignCfgError
);
   // Fixed sizes keep the alignment mask a factory constant; refuse anything else.
   if (NUM_OUT != `ODA_NUM_OUT || NUM_PLL != `ODA_NUM_PLL) begin : gBadSize
      $error("unsupported output or PLL count");
   end
   // The divider chain is only qualified across the PLL window.
   if (PLL_MHZ < `ODA_PLL_MIN_MHZ || PLL_MHZ > `ODA_PLL_MAX_MHZ) begin : gBadPll
      $error("PLL frequency out of range");
   end
   // The aligned group must name an existing PLL.
   if (ALIGN_PLL >= NUM_PLL) begin : gBadSrc
      $error("aligned PLL index out of range");
   end

   oda_pkg::oda_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [2:0] fsRef_q, fsRef_d;
   logic valid_q, valid_d, err_q, err_d;
   logic [NUM_OUT-1:0] divOut;
   logic [NUM_OUT-1:0] memberBad;
   logic [NUM_OUT-1:0] rawClk;
   logic syncRst;
   logic [2:0] fsNow;
   logic cfgBad;
   logic has4, has6, has12;

   assign fsNow = {freq_select_bit2, freq_select_bit1, freq_select_bit0};
   // The whole aligned group shares one reset release.
   assign syncRst = (state_q == oda_pkg::ODA_HOLD);

   // Per-output path and member configuration check.
   for (genvar i = 0; i < NUM_OUT; i++) begin : gPath
      oda_divider uDiv (
         .clk(clk),
         .rst(rst),
         .syncRst(syncRst),
         .preRatio(divCfg[i].preRatio),
         .linRatio(divCfg[i].linRatio),
         .clkOut(rawClk[i])
      );
      // Only the output's own PLL, when running, reaches the pin.
      assign divOut[i] = rawClk[i] & pllClkEn[divCfg[i].pllSel];
      always_comb begin
         memberBad[i] = 1'b0;
         if (ALIGN_MASK[i]) begin
            if (divCfg[i].pllSel != ALIGN_PLL) memberBad[i] = 1'b1;
            if (divCfg[i].preRatio != `ODA_PRE_ALIGN) memberBad[i] = 1'b1;
            if (!(divCfg[i].linRatio == `ODA_LIN_A || divCfg[i].linRatio == `ODA_LIN_B ||
                  divCfg[i].linRatio == `ODA_LIN_C || divCfg[i].linRatio == `ODA_LIN_D)) begin
               memberBad[i] = 1'b1;
            end
         end
      end
   end

   // Related frequencies: the largest aligned ratio must be a multiple of every other one.
   // Among 2, 4, 6 and 12 only a group holding 4 and 6 without 12 fails that test.
   always_comb begin
      has4 = 1'b0;
      has6 = 1'b0;
      has12 = 1'b0;
      cfgBad = |memberBad;
      for (int k = 0; k < NUM_OUT; k++) begin
         if (ALIGN_MASK[k]) begin
            if (divCfg[k].linRatio == `ODA_LIN_B) has4 = 1'b1;
            if (divCfg[k].linRatio == `ODA_LIN_C) has6 = 1'b1;
            if (divCfg[k].linRatio == `ODA_LIN_D) has12 = 1'b1;
         end
      end
      if (has4 && has6 && !has12) cfgBad = 1'b1;
   end

   // Startup: hold common reset, release, then watch select pins.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      fsRef_d = fsRef_q;
      valid_d = valid_q;
      err_d = cfgBad;
      case (state_q)
         oda_pkg::ODA_HOLD: begin
            fsRef_d = fsNow;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= `ODA_START_CYC) begin
               state_d = oda_pkg::ODA_RUN;
            end
         end
         oda_pkg::ODA_RUN: begin
            valid_d = ~cfgBad;
            if (fsNow != fsRef_q) begin
               state_d = oda_pkg::ODA_LOST;
               valid_d = 1'b0;
            end
         end
         oda_pkg::ODA_LOST: begin
            valid_d = 1'b0;
         end
         default: begin
            state_d = oda_pkg::ODA_HOLD;
            valid_d = 1'b0;
         end
      endcase
   end

   // Sequencer registers; ALIGN_MASK is a parameter, so no port can alter it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= oda_pkg::ODA_HOLD;
         cnt_q <= 4'h0;
         fsRef_q <= 3'h0;
         valid_q <= 1'b0;
         err_q <= 1'b0;
         clkOut <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         fsRef_q <= fsRef_d;
         valid_q <= valid_d;
         err_q <= err_d;
         clkOut <= divOut;
      end
   end
   assign alignValid = valid_q;
   assign alignCfgError = err_q;

   // Two aligned outputs with equal ratios match on both edges.
   for (genvar a = 1; a < NUM_OUT; a++) begin : gChk
      same_edge_a: assert property (@(posedge clk) disable iff (rst)
         (alignValid && ALIGN_MASK[0] && ALIGN_MASK[a] && pllClkEn[ALIGN_PLL] &&
          $stable(divCfg) && divCfg[0].linRatio == divCfg[a].linRatio)
         |-> clkOut[0] == clkOut[a])
         else $error("equal-ratio aligned outputs differ");
      // Ratios 6 and 4 share no member base frequency unless 12 is also present.
      related_group_a: assert property (@(posedge clk) disable iff (rst)
         (ALIGN_MASK[0] && ALIGN_MASK[a] && divCfg[0].linRatio == 8'h06 &&
          divCfg[a].linRatio == 8'h04 && !has12) |=> alignCfgError)
         else $error("unrelated aligned ratios not flagged");
      // An output whose source is stopped stays low at the pin.
      gated_low_a: assert property (@(posedge clk) disable iff (rst)
         !pllClkEn[divCfg[a].pllSel] |=> !clkOut[a])
         else $error("output of stopped source toggled");
      // Every live member rises two edges after the common reset lets go.
      rise_first_a: assert property (@(posedge clk) disable iff (rst)
         ($fell(syncRst) && ALIGN_MASK[a] && !cfgBad && pllClkEn[ALIGN_PLL])
         |-> ##2 clkOut[a])
         else $error("aligned member missed the first common rise");
   end
   // Output 1 rises only while output 0, whose ratio divides its own, is high.
   rise_together_a: assert property (@(posedge clk) disable iff (rst)
      (alignValid && ALIGN_MASK[1] && ALIGN_MASK[0] && $rose(clkOut[1]) && $stable(divCfg) &&
       divCfg[0].linRatio != 8'h00 && (divCfg[1].linRatio % divCfg[0].linRatio) == 8'h00)
      |-> clkOut[0])
      else $error("aligned member rose while reference low");
   // The common reset lets go only after the full hold count.
   hold_release_a: assert property (@(posedge clk) disable iff (rst)
      $fell(syncRst) |-> $past(cnt_q) == 4'h3)
      else $error("common reset released at wrong count");
   // Dividers sit low while the common reset is held.
   hold_low_a: assert property (@(posedge clk) disable iff (rst)
      syncRst |=> clkOut == '0)
      else $error("output moved during common reset");
   // A select pin change drops alignment at once and for good.
   fs_loss_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == oda_pkg::ODA_RUN && fsNow != fsRef_q) |=> !alignValid [*3])
      else $error("alignment kept after select change");
   // Only a reset leaves the lost state.
   lost_stays_a: assert property (@(posedge clk) disable iff (rst)
      (state_q == oda_pkg::ODA_LOST) |=> state_q == oda_pkg::ODA_LOST)
      else $error("alignment restored without power cycle");
   // A member on a foreign PLL is reported.
   pll_cross_a: assert property (@(posedge clk) disable iff (rst)
      (ALIGN_MASK[0] && divCfg[0].pllSel != ALIGN_PLL) |=> alignCfgError)
      else $error("foreign PLL member not flagged");
   // A member with a dividing prescaler is reported and never aligned.
   prescale_one_a: assert property (@(posedge clk) disable iff (rst)
      (ALIGN_MASK[0] && divCfg[0].preRatio != 8'h01) |=> !alignValid && alignCfgError)
      else $error("prescaler ratio not flagged");
   // A linear ratio outside the permitted set is reported.
   lin_ratio_a: assert property (@(posedge clk) disable iff (rst)
      (ALIGN_MASK[0] && divCfg[0].linRatio == 8'h08) |=> alignCfgError)
      else $error("unsupported linear ratio not flagged");
   // An illegal group never reports alignment.
   err_excl_a: assert property (@(posedge clk) disable iff (rst)
      alignCfgError |-> !alignValid)
      else $error("alignment reported on illegal group");
   // Alignment is announced only from the run state on a clean group.
   valid_cause_a: assert property (@(posedge clk) disable iff (rst)
      $rose(alignValid) |-> $past(state_q) == oda_pkg::ODA_RUN && !$past(cfgBad))
      else $error("valid raised on bad group");
endmodule : output_divider_edge_align
`default_nettype wire

//--- verification/oda_clk_sink.sv
`default_nettype none
// Downstream sink: flags edges and measures period and high time per output.
module oda_clk_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic [8:0] clkIn,
   output logic [8:0] rose,
   output logic [8:0] fell,
   output logic [8:0][7:0] period,
   output logic [8:0][7:0] highTime
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] prev_q;
   logic [8:0][7:0] since_q;
   // Edges compare the level now with the level one cycle earlier.
   assign rose = clkIn & ~prev_q;
   assign fell = ~clkIn & prev_q;
   // The span counter restarts at each rise, so it holds the period at the next rise.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= 9'h000;
         since_q <= '0;
         period <= '0;
         highTime <= '0;
      end else begin
         prev_q <= clkIn;
         for (int i = 0; i < 9; i++) begin
            since_q[i] <= rose[i] ? 8'h01 : since_q[i] + 8'h01;
            if (rose[i]) period[i] <= since_q[i];
            if (fell[i]) highTime[i] <= since_q[i];
         end
      end
   end
endmodule : oda_clk_sink
`default_nettype wire

//--- verification/output_divider_edge_align_tb_top.sv
`default_nettype none
module output_divider_edge_align_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, alignValid, alignCfgError, gone;
   logic freq_select_bit0, freq_select_bit1, freq_select_bit2;
   logic [3:0] pllClkEn;
   oda_pkg::oda_div_cfg_t [8:0] divCfg;
   logic [8:0] clkOut, rose, fell;
   logic [8:0][7:0] period, highTime;
   logic [7:0] ratios [4] = '{8'h02, 8'h04, 8'h06, 8'h0C};
   int badCount = 0;
   int checksDone = 0;
   output_divider_edge_align i_dut (.clk(clk), .rst(rst), .pllClkEn(pllClkEn),
      .divCfg(divCfg), .freq_select_bit0(freq_select_bit0),
      .freq_select_bit1(freq_select_bit1), .freq_select_bit2(freq_select_bit2),
      .clkOut(clkOut), .alignValid(alignValid), .alignCfgError(alignCfgError));
   oda_clk_sink i_sink (.clk(clk), .rst(rst), .clkIn(clkOut), .rose(rose), .fell(fell),
      .period(period), .highTime(highTime));
   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Power cycle with outputs 1-3 on PLL 0 and output 0 on PLL sel; outputs 4-8 run unaligned at 2 x 3.
   task automatic powerUp(input logic [3:0][7:0] lin, input logic [7:0] pre,
      input logic [1:0] sel, input logic expErr);
      @(negedge clk);
      rst = 1'b1;
      {freq_select_bit2, freq_select_bit1, freq_select_bit0} = 3'h0;
      for (int i = 0; i < 9; i++) divCfg[i] = '{2'h1, 8'h02, 8'h03};
      for (int i = 0; i < 4; i++) divCfg[i] = '{2'h0, 8'h01, lin[i]};
      divCfg[0].preRatio = pre;
      divCfg[0].pllSel = sel;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (12) @(negedge clk);
      check("alignCfgError", {7'h00, expErr}, {7'h00, alignCfgError});
      check("alignValid", {7'h00, ~expErr}, {7'h00, alignValid});
   endtask : powerUp
   // Watches the aligned group for 30 cycles, then checks the measured shapes.
   task automatic watch(input logic [3:0][7:0] lin);
      for (int n = 0; n < 30; n++) begin
         @(negedge clk);
         if (rose[3] === 1'b1) check("rise group", 8'h0F, {4'h0, rose[3:0]});
         check("fall pair", {7'h00, fell[3]}, {7'h00, fell[2]});
      end
      for (int i = 0; i < 4; i++) begin
         check("period", lin[i], period[i]);
         check("high time", lin[i] >> 1, highTime[i]);
      end
      check("unaligned period", 8'h06, period[4]);
   endtask : watch
   // Prints the counts and the verdict, then stops.
   task automatic endSim();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : endSim
   // Free-running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Cuts a hang short well beyond the expected run time.
   initial begin
      #40000;
      badCount++;
      endSim();
   end
   // Test sequence.
   initial begin
      rst = 1'b1;
      pllClkEn = 4'hF;
      divCfg = '0;
      {freq_select_bit2, freq_select_bit1, freq_select_bit0} = 3'h0;
      foreach (ratios[k]) begin
         powerUp({4{ratios[k]}}, 8'h01, 2'h0, 1'b0);
         watch({4{ratios[k]}});
      end
      $display("test same frequency done");
      powerUp({8'h0C, 8'h0C, 8'h04, 8'h02}, 8'h01, 2'h0, 1'b0);
      watch({8'h0C, 8'h0C, 8'h04, 8'h02});
      powerUp({8'h06, 8'h06, 8'h02, 8'h02}, 8'h01, 2'h0, 1'b0);
      watch({8'h06, 8'h06, 8'h02, 8'h02});
      $display("test related frequencies done");
      powerUp({8'h0C, 8'h0C, 8'h04, 8'h08}, 8'h01, 2'h0, 1'b1);
      powerUp({8'h04, 8'h04, 8'h06, 8'h06}, 8'h01, 2'h0, 1'b1);
      powerUp({4{8'h04}}, 8'h02, 2'h0, 1'b1);
      powerUp({4{8'h04}}, 8'h01, 2'h1, 1'b1);
      $display("test illegal groups done");
      for (int b = 0; b < 3; b++) begin
         powerUp({4{8'h04}}, 8'h01, 2'h0, 1'b0);
         {freq_select_bit2, freq_select_bit1, freq_select_bit0} = 3'h1 << b;
         repeat (2) @(negedge clk);
         check("alignValid after select", 8'h00, {7'h00, alignValid});
         {freq_select_bit2, freq_select_bit1, freq_select_bit0} = 3'h0;
         repeat (2) @(negedge clk);
         check("alignValid stays lost", 8'h00, {7'h00, alignValid});
      end
      $display("test select change done");
      powerUp({4{8'h04}}, 8'h01, 2'h0, 1'b0);
      pllClkEn = 4'hD;
      repeat (4) @(negedge clk);
      gone = 1'b0;
      repeat (12) begin
         @(negedge clk);
         gone = gone | rose[4];
      end
      check("stopped source rises", 8'h00, {7'h00, gone});
      check("running source period", 8'h04, period[0]);
      pllClkEn = 4'hF;
      $display("test source enable done");
      endSim();
   end
endmodule : output_divider_edge_align_tb_top
`default_nettype wire
